// [bench/dwp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dwp_host_model (
    // Master side of the link
    output logic scl_out,
    output logic sda_oe_out,
    input wire logic sda_in
);
    logic lclk = 1'b0; // 12 ns base; clock line idles high between frames
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
        #3;
        forever #6 lclk = ~lclk;
    end
    // Phases kept long so the slave's sync stages see each level
    task automatic hp(input int n);
        repeat (n) @(posedge lclk);
    endtask : hp
    // Data falls while clock high
    task automatic start();
        sda_oe_out = 1'b1;
        hp(64);
        scl_out = 1'b0;
        hp(16);
    endtask : start
    // Data rises while clock high
    task automatic stop();
        sda_oe_out = 1'b1;
        hp(48);
        scl_out = 1'b1;
        hp(64);
        sda_oe_out = 1'b0;
        hp(64);
    endtask : stop
    // One clock pulse; data only changes while clock low
    task automatic bit_cyc(input logic b, output logic r);
        sda_oe_out = ~b;
        hp(48);
        scl_out = 1'b1;
        hp(64);
        r = sda_in;
        scl_out = 1'b0;
        hp(16);
    endtask : bit_cyc
    // Eight bits MSB first, then the ninth clock
    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] rd,
                        output logic r9);
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], rd[i]);
        end
        bit_cyc(b9, r9);
    endtask : xfer
endmodule : dwp_host_model
`default_nettype wire

// [bench/dwp_wiper_slave_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dwp_cfg.svh"
module dwp_wiper_slave_chk #(
    parameter int unsigned NV_WRITE_CYCLES = 40
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Link lines
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [3:0] device_address_pins_in,
    // Wiper side
    input wire dwp_pkg::dwp_pos_t wiper0_pos_out,
    input wire dwp_pkg::dwp_pos_t wiper1_pos_out,
    input wire logic [`DWP_TAPS-1:0] tap0_sel_out,
    input wire logic [`DWP_TAPS-1:0] tap1_sel_out,
    input wire logic nv_busy_out
);
    import dwp_pkg::*;
    logic [31:0] busy_cnt_ff; // Cycles of the current write
    logic [31:0] nxt_busy_cnt;
    assign nxt_busy_cnt = nv_busy_out ? busy_cnt_ff + 32'h1 : 32'h0;
    // Busy length counter; too long for a repetition
    always_ff @(posedge clk_sys_in) begin
        busy_cnt_ff <= reset_n_in ? nxt_busy_cnt : 32'h0;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    property p_tap_onehot;
        $onehot(tap0_sel_out) && $onehot(tap1_sel_out);
    endproperty
    a_tap_onehot: assert property (p_tap_onehot) else $error("tap not one-hot");
    property p_tap_follow;
        $past(reset_n_in) |-> tap0_sel_out == (64'h1 << $past(wiper0_pos_out))
            && tap1_sel_out == (64'h1 << $past(wiper1_pos_out));
    endproperty
    a_tap_follow: assert property (p_tap_follow) else $error("tap not at wiper");
    // Device only moves data while the clock is low
    property p_oe_rise_low;
        $rose(sda_oe_out) |-> !scl_in && !$past(scl_in, 2);
    endproperty
    a_oe_rise_low: assert property (p_oe_rise_low) else $error("drive in clock high");
    property p_oe_hold;
        $rose(sda_oe_out) |-> sda_oe_out [*8];
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
    property p_busy_quiet;
        nv_busy_out |-> !sda_oe_out;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("answer while busy");
    property p_busy_start;
        $rose(nv_busy_out) |-> scl_in && sda_in;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("write not after stop");
    property p_busy_len;
        $fell(nv_busy_out) |-> busy_cnt_ff == NV_WRITE_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length");
    property p_busy_wiper;
        nv_busy_out && $past(nv_busy_out) |-> $stable(wiper0_pos_out) && $stable(wiper1_pos_out);
    endproperty
    a_busy_wiper: assert property (p_busy_wiper) else $error("wiper moved while busy");
    c_busy: cover property ($rose(nv_busy_out));
    c_ack: cover property ($rose(sda_oe_out));
    c_wiper: cover property ($changed(wiper1_pos_out));
endmodule : dwp_wiper_slave_chk
bind dwp_wiper_slave dwp_wiper_slave_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .device_address_pins_in(device_address_pins_in),
    .wiper0_pos_out(wiper0_pos_out), .wiper1_pos_out(wiper1_pos_out),
    .tap0_sel_out(tap0_sel_out), .tap1_sel_out(tap1_sel_out), .nv_busy_out(nv_busy_out));
`default_nettype wire

// [bench/dwp_wiper_slave_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module dwp_wiper_slave_tb_top;
    import dwp_pkg::*;
    localparam logic [3:0] TYPE_ID = 4'h6; // Type code, value arbitrary
    localparam int NV_CYC = 400; // Shortened write cycle, outlasts one address byte
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] pins = 4'h0;
    logic scl, h_oe, sda_o, sda_oe, busy, r9;
    wire logic sda_w;
    dwp_pos_t w0, w1;
    logic [63:0] t0, t1;
    logic [5:0] set_m [2][4]; // Expected stored settings
    logic [5:0] wip [2]; // Expected wipers
    logic [7:0] bad_ops [8] = '{8'h00, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'hf0, 8'h98};
    logic [7:0] exp_q [$];
    string nm_q [$];
    logic [7:0] res, rd;
    event res_ev;
    int n_mismatch = 0;
    int n_checks = 0;
    assign sda_w = ~((sda_oe & ~sda_o) | h_oe); // Pull-up wire
    initial forever #50 clk_sys_in = ~clk_sys_in;
    dwp_wiper_slave #(.DEVICE_TYPE_ID(TYPE_ID), .NV_WRITE_CYCLES(NV_CYC)) dut (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .device_address_pins_in(pins),
        .wiper0_pos_out(w0), .wiper1_pos_out(w1), .tap0_sel_out(t0), .tap1_sel_out(t1),
        .nv_busy_out(busy));
    dwp_host_model host (.scl_out(scl), .sda_oe_out(h_oe), .sda_in(sda_w));
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Driver leaves the expectation, monitor compares
    task automatic note(input string nm, input logic [7:0] got, input logic [7:0] exp);
        exp_q.push_back(exp);
        nm_q.push_back(nm);
        res = got;
        -> res_ev;
        #1;
    endtask : note
    always @(res_ev) begin
        chk(nm_q.pop_front(), res, exp_q.pop_front());
    end
    task automatic wb(input logic [7:0] d, input logic ack);
        host.xfer(d, 1'b1, rd, r9);
        note("ack", {7'h0, ~r9}, {7'h0, ack});
    endtask : wb
    task automatic op(input logic [7:0] ins, input logic ack);
        host.start();
        wb({TYPE_ID, pins}, 1'b1);
        wb(ins, ack);
    endtask : op
    task automatic rdb(input logic [7:0] e);
        host.xfer(8'hff, 1'b1, rd, r9);
        note("data", rd, e);
        host.stop();
    endtask : rdb
    task automatic rdset(input logic p, input logic [1:0] s);
        wb({4'hb, 1'b0, p, s}, 1'b1);
        rdb({2'h0, set_m[p][s]});
    endtask : rdset
    // Address polling; leaves the frame open after the accepted address
    task automatic poll(input logic bz);
        int n;
        n = 0;
        note("busy", {7'h0, busy}, {7'h0, bz});
        do begin
            if (n > 0) host.stop();
            host.start();
            host.xfer({TYPE_ID, pins}, 1'b1, rd, r9);
            n++;
        end while (r9 && n < 100);
        note("poll", {6'h0, r9, n > 1}, {7'h0, bz});
    endtask : poll
    task automatic cw();
        note("wiper0", {2'h0, w0}, {2'h0, wip[0]});
        note("wiper1", {2'h0, w1}, {2'h0, wip[1]});
        note("taps", {6'h0, t1 == (64'h1 << wip[1]), t0 == (64'h1 << wip[0])}, 8'h03);
    endtask : cw
    task automatic step(input logic b, input int n, input logic [7:0] e);
        repeat (n) host.bit_cyc(b, r9);
        note("step", {2'h0, w1}, e);
    endtask : step
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #8_000_000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        logic [7:0] d;
        logic [1:0] s;
        void'($urandom(84511));
        pins = 4'($urandom);
        wip = '{6'h0, 6'h0};
        repeat (3) @(posedge clk_sys_in);
        #2 reset_n_in = 1'b1;
        repeat (5) @(posedge clk_sys_in);
        cw();
        host.start();
        wb({~TYPE_ID, pins}, 1'b0);
        host.stop();
        host.start();
        wb({TYPE_ID, pins ^ 4'h8}, 1'b0);
        host.stop();
        for (int i = 0; i < 8; i++) begin
            set_m[i[2]][i[1:0]] = 6'($urandom);
            op({4'hc, 1'b0, i[2:0]}, 1'b1);
            wb({2'h3, set_m[i[2]][i[1:0]]}, 1'b1);
            host.stop();
            poll(1'b1);
            rdset(i[2], i[1:0]);
        end
        for (int p = 0; p < 2; p++) begin
            d = 8'($urandom);
            s = 2'($urandom);
            wip[p] = d[5:0];
            op({4'ha, 1'b0, p[0], s}, 1'b1);
            wb(d, 1'b1);
            host.stop();
            op({4'h9, 1'b0, p[0], ~s}, 1'b1);
            rdb({2'h0, wip[p]});
            op({4'he, 1'b0, p[0], s}, 1'b1);
            host.stop();
            set_m[p][s] = wip[p];
            poll(1'b1);
            rdset(p[0], s);
            op({4'hd, 1'b0, p[0], ~s}, 1'b1);
            wb(8'h00, 1'b0);
            host.stop();
            wip[p] = set_m[p][~s];
            cw();
        end
        s = 2'($urandom);
        op({4'h1, 2'h3, s}, 1'b1);
        host.stop();
        wip = '{set_m[0][s], set_m[1][s]};
        cw();
        op(8'ha4, 1'b1);
        wb(8'h3e, 1'b1);
        host.stop();
        op(8'h24, 1'b1);
        step(1'b1, 3, 8'h3f);
        step(1'b0, 2, 8'h3d);
        step(1'b0, 70, 8'h00);
        host.stop();
        wip[1] = 6'h00;
        s = s + 2'h1;
        op({4'h8, 2'h1, s}, 1'b1);
        host.stop();
        set_m[0][s] = wip[0];
        set_m[1][s] = wip[1];
        poll(1'b1);
        rdset(1'b0, s);
        poll(1'b0);
        rdset(1'b1, s);
        foreach (bad_ops[k]) begin
            op(bad_ops[k], 1'b0);
            host.stop();
        end
        cw();
        print_verdict();
    end
endmodule : dwp_wiper_slave_tb_top
`default_nettype wire

// [verilog/dwp_cfg.svh]
`ifndef DWP_CFG_SVH
`define DWP_CFG_SVH

// Widths and counts
`define DWP_POS_W 6
`define DWP_TAPS 64
`define DWP_BYTE_W 8
`define DWP_NUM_POTS 2
`define DWP_NUM_SETTINGS 4
`define DWP_SEL_W 2

// Byte field positions
`define DWP_OPC_HI 7
`define DWP_OPC_LO 4
`define DWP_ZERO_BIT 3
`define DWP_POT_BIT 2
`define DWP_SEL_HI 1
`define DWP_SEL_LO 0
`define DWP_DEV_HI 3
`define DWP_DEV_LO 0

// Opcodes
`define DWP_OP_RD_WIPER 4'h9
`define DWP_OP_WR_WIPER 4'ha
`define DWP_OP_RD_SETTING 4'hb
`define DWP_OP_WR_SETTING 4'hc
`define DWP_OP_COPY_SETTING_TO_WIPER 4'hd
`define DWP_OP_COPY_WIPER_TO_SETTING 4'he
`define DWP_OP_GLB_COPY_SETTING 4'h1
`define DWP_OP_GLB_SAVE_WIPER 4'h8
`define DWP_OP_STEP 4'h2

// Bit counter points
`define DWP_LAST_BIT 4'h7
`define DWP_ACK_BIT 4'h8

// Reset values and data drive level
`define DWP_POS_RESET 6'h00
`define DWP_LINE_IDLE 2'h3
`define DWP_ADDR_RESET 4'h0
`define DWP_SDA_DRIVE_LVL 1'h0

// Timing
`define DWP_NONVOLATILE_WRITE_TIME_US 5000
`define DWP_CLK_FREQ_MHZ 10
`endif

// [verilog/dwp_link_capture.sv]
`timescale 1ns/1ps
`default_nettype none
module dwp_link_capture #(
    parameter int WIDTH = 8
) (
    // Serial clock domain
    input wire logic scl_clk_in,
    input wire logic sda_in,
    // Most recent bits, newest in bit 0
    output logic [WIDTH-1:0] shift_out
);
    logic [WIDTH-1:0] shift_ff; // Holds between clock rises

    // Sample data on each rising serial clock; no reset needed since the
    // system side only reads this after a synchronised clock rise
    always_ff @(posedge scl_clk_in) begin
        shift_ff <= {shift_ff[WIDTH-2:0], sda_in};
    end

    assign shift_out = shift_ff;
endmodule : dwp_link_capture
`default_nettype wire

// [verilog/dwp_pkg.sv]
`include "dwp_cfg.svh"
package dwp_pkg;
    // Wiper position and setting value
    typedef logic [`DWP_POS_W-1:0] dwp_pos_t;
    // Serial protocol states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WR, ST_RD, ST_INC_ARM, ST_INC, ST_SKIP
    } dwp_state_t;
endpackage : dwp_pkg

// [verilog/dwp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module dwp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff; // First stage, read only by second
    logic [WIDTH-1:0] sync_ff; // Second stage

    // Two-stage synchroniser
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : dwp_sync
`default_nettype wire

// [verilog/dwp_wiper_slave.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dwp_cfg.svh"
module dwp_wiper_slave #(
    // Type identifier; value is arbitrary
    parameter logic [3:0] DEVICE_TYPE_ID = 4'ha,
    // Nonvolatile write busy time in system clocks
    parameter int unsigned NV_WRITE_CYCLES =
        `DWP_NONVOLATILE_WRITE_TIME_US * `DWP_CLK_FREQ_MHZ
) (
    // System clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Two-wire link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Device address straps
    input wire logic [3:0] device_address_pins_in,
    // Wiper positions and tap selections
    output dwp_pkg::dwp_pos_t wiper0_pos_out,
    output dwp_pkg::dwp_pos_t wiper1_pos_out,
    output logic [`DWP_TAPS-1:0] tap0_sel_out,
    output logic [`DWP_TAPS-1:0] tap1_sel_out,
    // Nonvolatile write in progress
    output logic nv_busy_out
);
    import dwp_pkg::*;

    localparam int BUSY_W = $clog2(NV_WRITE_CYCLES + 1);

    // Synchronised pins
    logic [1:0] line_s; // {scl, sda}
    logic [3:0] addr_s; // Address straps
    logic [`DWP_BYTE_W-1:0] link_byte; // Captured in serial domain

    // Line history
    logic scl_prev_ff;
    logic sda_prev_ff;

    // Protocol state
    dwp_state_t state_ff;
    dwp_state_t nxt_state;
    logic ack_pend_ff; // Ack to drive on ninth clock
    logic nxt_ack_pend;
    logic [3:0] bit_cnt_ff; // Rises seen in current byte
    logic [3:0] cmd_op_ff; // Latched opcode
    logic cmd_pot_ff; // Latched pot select
    logic [`DWP_SEL_W-1:0] cmd_sel_ff; // Latched setting select
    logic [`DWP_BYTE_W-1:0] rd_byte_ff; // Byte being returned
    logic sda_oe_ff; // Pulling data low

    // Pending nonvolatile write
    logic nv_pend_ff;
    logic [`DWP_NUM_POTS-1:0] nv_mask_ff;
    logic [`DWP_SEL_W-1:0] nv_sel_ff;
    dwp_pos_t nv_data_ff;
    logic nv_from_wiper_ff;
    logic [BUSY_W-1:0] busy_cnt_ff;
    logic nv_busy_ff;
    logic recall_ff; // Load from setting zero after reset

    // Register storage
    dwp_pos_t wiper_position_register_ff [0:`DWP_NUM_POTS-1];
    dwp_pos_t setting_ff [0:`DWP_NUM_POTS-1][0:`DWP_NUM_SETTINGS-1];
    logic [`DWP_TAPS-1:0] tap_ff [0:`DWP_NUM_POTS-1];

    // Synchronise clock and data lines for start and stop detection
    dwp_sync #(
        .WIDTH(2),
        .RESET_VAL(`DWP_LINE_IDLE)
    ) u_line_sync (
        .clk_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .async_in({scl_in, sda_in}),
        .sync_out(line_s)
    );

    // Address straps are pins too
    dwp_sync #(
        .WIDTH(4),
        .RESET_VAL(`DWP_ADDR_RESET)
    ) u_addr_sync (
        .clk_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .async_in(device_address_pins_in),
        .sync_out(addr_s)
    );

    // Bits are captured on the link's own clock
    dwp_link_capture #(
        .WIDTH(`DWP_BYTE_W)
    ) u_capture (
        .scl_clk_in(scl_in),
        .sda_in(sda_in),
        .shift_out(link_byte)
    );

    // Line events
    wire logic scl_s = line_s[1];
    wire logic sda_s = line_s[0];
    wire logic scl_rise = scl_s & ~scl_prev_ff;
    wire logic scl_fall = ~scl_s & scl_prev_ff;
    // Data edges with clock high mark frame bounds, never bits
    wire logic start_evt = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
    wire logic stop_evt = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

    // Bit timing; idle ignores traffic until a start
    wire logic bit_rise = scl_rise && (state_ff != ST_IDLE) && (state_ff != ST_INC);
    wire logic byte_done = bit_rise && (bit_cnt_ff == `DWP_LAST_BIT);
    wire logic ack_done = bit_rise && (bit_cnt_ff == `DWP_ACK_BIT);

    // Instruction fields
    wire logic [3:0] opcode = link_byte[`DWP_OPC_HI:`DWP_OPC_LO];
    wire logic opcode_bit_three = link_byte[`DWP_ZERO_BIT];
    wire logic pot_select_bit = link_byte[`DWP_POT_BIT];
    wire logic [`DWP_SEL_W-1:0] setting_select = link_byte[`DWP_SEL_HI:`DWP_SEL_LO];

    // Address compare; busy write cycle blocks the ack
    wire logic type_ok = link_byte[`DWP_OPC_HI:`DWP_OPC_LO] == DEVICE_TYPE_ID;
    wire logic dev_ok = link_byte[`DWP_DEV_HI:`DWP_DEV_LO] == addr_s;
    wire logic addr_match = type_ok && dev_ok && !nv_busy_ff;

    // Opcode decode
    wire logic op_glb_load = opcode == `DWP_OP_GLB_COPY_SETTING;
    wire logic op_glb_save = opcode == `DWP_OP_GLB_SAVE_WIPER;
    wire logic op_global = op_glb_load || op_glb_save;
    wire logic op_local = (opcode == `DWP_OP_RD_WIPER) || (opcode == `DWP_OP_WR_WIPER)
        || (opcode == `DWP_OP_RD_SETTING) || (opcode == `DWP_OP_WR_SETTING)
        || (opcode == `DWP_OP_COPY_SETTING_TO_WIPER)
        || (opcode == `DWP_OP_COPY_WIPER_TO_SETTING) || (opcode == `DWP_OP_STEP);
    // Unknown opcodes, or a set zero bit on a local opcode, get no ack
    wire logic cmd_valid = op_global || (op_local && !opcode_bit_three);
    wire logic op_two_byte = op_global
        || (opcode == `DWP_OP_COPY_SETTING_TO_WIPER)
        || (opcode == `DWP_OP_COPY_WIPER_TO_SETTING);
    wire logic op_read = (opcode == `DWP_OP_RD_WIPER) || (opcode == `DWP_OP_RD_SETTING);
    wire logic op_write = (opcode == `DWP_OP_WR_WIPER) || (opcode == `DWP_OP_WR_SETTING);

    // State after the instruction byte
    wire dwp_state_t cmd_next = !cmd_valid ? ST_SKIP
        : op_two_byte ? ST_SKIP
        : op_read ? ST_RD
        : op_write ? ST_WR
        : ST_INC_ARM;

    // Command byte actions
    wire logic cmd_evt = byte_done && (state_ff == ST_CMD) && cmd_valid;
    wire logic copy_vol_evt = cmd_evt
        && (op_glb_load || opcode == `DWP_OP_COPY_SETTING_TO_WIPER);
    wire logic save_evt = cmd_evt
        && (op_glb_save || opcode == `DWP_OP_COPY_WIPER_TO_SETTING);
    // Data byte actions
    wire logic data_evt = byte_done && (state_ff == ST_WR);
    wire logic wr_wiper_evt = data_evt && (cmd_op_ff == `DWP_OP_WR_WIPER);
    wire logic wr_set_evt = data_evt && (cmd_op_ff == `DWP_OP_WR_SETTING);
    // Stepping uses the data level captured at the clock rise
    wire logic step_evt = scl_rise && (state_ff == ST_INC);
    wire logic step_up = link_byte[0];

    // Read data: register select ignored for wiper reads
    wire dwp_pos_t rd_wiper = wiper_position_register_ff[pot_select_bit];
    wire dwp_pos_t rd_setting = setting_ff[pot_select_bit][setting_select];
    wire logic [`DWP_BYTE_W-1:0] rd_value = {{(`DWP_BYTE_W-`DWP_POS_W){1'b0}},
        ((opcode == `DWP_OP_RD_WIPER) ? rd_wiper : rd_setting)};

    // Nonvolatile commit at the stop that ends the command
    wire logic nv_commit = stop_evt && nv_pend_ff;
    wire logic [`DWP_NUM_POTS-1:0] cmd_pot_mask = op_global ? {`DWP_NUM_POTS{1'b1}}
        : (pot_select_bit ? 2'b10 : 2'b01);

    // Drive value for the next low phase
    wire logic [2:0] rd_idx = 3'h7 - bit_cnt_ff[2:0];
    wire logic nxt_sda_oe = (bit_cnt_ff == `DWP_ACK_BIT) ? ack_pend_ff
        : ((state_ff == ST_RD) && (bit_cnt_ff <= `DWP_LAST_BIT)) ? ~rd_byte_ff[rd_idx]
        : 1'b0;

    // Protocol sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_ack_pend = ack_pend_ff;
        if (start_evt) begin
            // Repeated start restarts address phase
            nxt_state = ST_ADDR;
            nxt_ack_pend = 1'b0;
        end else if (stop_evt) begin
            nxt_state = ST_IDLE;
            nxt_ack_pend = 1'b0;
        end else if (ack_done) begin
            // Ninth clock over; stepping starts only after it
            nxt_ack_pend = 1'b0;
            if (state_ff == ST_INC_ARM) begin
                nxt_state = ST_INC;
            end
        end else if (byte_done) begin
            case (state_ff)
                ST_ADDR: begin
                    nxt_ack_pend = addr_match;
                    nxt_state = addr_match ? ST_CMD : ST_SKIP;
                end
                ST_CMD: begin
                    nxt_ack_pend = cmd_valid;
                    nxt_state = cmd_next;
                end
                ST_WR: begin
                    nxt_ack_pend = 1'b1;
                    nxt_state = ST_SKIP;
                end
                default: begin
                    // Master acks read data; extra bytes ignored
                    nxt_ack_pend = 1'b0;
                    nxt_state = ST_SKIP;
                end
            endcase
        end
    end

    // Line history and state
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
            state_ff <= ST_IDLE;
            ack_pend_ff <= 1'b0;
        end else begin
            scl_prev_ff <= scl_s;
            sda_prev_ff <= sda_s;
            state_ff <= nxt_state;
            ack_pend_ff <= nxt_ack_pend;
        end
    end

    // Bit counter: eight data clocks then the ack clock
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || start_evt || stop_evt) begin
            bit_cnt_ff <= 4'h0;
        end else if (bit_rise) begin
            bit_cnt_ff <= ack_done ? 4'h0 : bit_cnt_ff + 4'h1;
        end
    end

    // Data line drive changes after clock falls; a start or stop releases it with clock high
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || start_evt || stop_evt) begin
            sda_oe_ff <= 1'b0;
        end else if (scl_fall) begin
            sda_oe_ff <= nxt_sda_oe;
        end
    end

    // Latch the instruction and read data
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            cmd_op_ff <= 4'h0;
            cmd_pot_ff <= 1'b0;
            cmd_sel_ff <= '0;
            rd_byte_ff <= '0;
        end else if (cmd_evt) begin
            cmd_op_ff <= opcode;
            cmd_pot_ff <= pot_select_bit;
            cmd_sel_ff <= setting_select;
            rd_byte_ff <= rd_value;
        end
    end

    // Pending nonvolatile write, committed only by a stop
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || start_evt || nv_commit) begin
            nv_pend_ff <= 1'b0;
        end else if (save_evt || wr_set_evt) begin
            nv_pend_ff <= 1'b1;
        end
    end

    // What the pending write stores and where
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            nv_mask_ff <= '0;
            nv_sel_ff <= '0;
            nv_data_ff <= `DWP_POS_RESET;
            nv_from_wiper_ff <= 1'b0;
        end else if (save_evt) begin
            nv_mask_ff <= cmd_pot_mask;
            nv_sel_ff <= setting_select;
            nv_from_wiper_ff <= 1'b1;
        end else if (wr_set_evt) begin
            nv_mask_ff <= cmd_pot_ff ? 2'b10 : 2'b01;
            nv_sel_ff <= cmd_sel_ff;
            nv_data_ff <= link_byte[`DWP_POS_W-1:0];
            nv_from_wiper_ff <= 1'b0;
        end
    end

    // Write cycle timer; addresses go unacked while it runs
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            busy_cnt_ff <= '0;
            nv_busy_ff <= 1'b0;
        end else if (nv_commit) begin
            busy_cnt_ff <= BUSY_W'(NV_WRITE_CYCLES);
            nv_busy_ff <= 1'b1;
        end else if (busy_cnt_ff != '0) begin
            busy_cnt_ff <= busy_cnt_ff - BUSY_W'(1);
            nv_busy_ff <= (busy_cnt_ff != BUSY_W'(1));
        end
    end

    // Held for one cycle after reset, then wipers recall setting zero
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            recall_ff <= 1'b1;
        end else begin
            recall_ff <= 1'b0;
        end
    end

    // Per-pot registers and tap decode
    for (genvar p = 0; p < `DWP_NUM_POTS; p++) begin : g_pot
        localparam logic PIDX = 1'(p);
        wire dwp_pos_t cur = wiper_position_register_ff[p];
        wire logic load_copy = copy_vol_evt && (op_global || pot_select_bit == PIDX);
        wire logic load_write = wr_wiper_evt && (cmd_pot_ff == PIDX);
        wire logic step_hit = step_evt && (cmd_pot_ff == PIDX);
        wire logic at_top = cur == {`DWP_POS_W{1'b1}};
        wire logic at_bot = cur == `DWP_POS_RESET;
        wire logic set_we = nv_commit && nv_mask_ff[p];
        wire dwp_pos_t set_val = nv_from_wiper_ff ? cur : nv_data_ff;

        // Wiper updates; recall first, then copy, write, step
        always_ff @(posedge clk_sys_in) begin
            if (!reset_n_in) begin
                wiper_position_register_ff[p] <= `DWP_POS_RESET;
            end else if (recall_ff) begin
                wiper_position_register_ff[p] <= setting_ff[p][0];
            end else if (load_copy) begin
                wiper_position_register_ff[p] <= setting_ff[p][setting_select];
            end else if (load_write) begin
                // Upper data bits dropped
                wiper_position_register_ff[p] <= link_byte[`DWP_POS_W-1:0];
            end else if (step_hit && step_up && !at_top) begin
                wiper_position_register_ff[p] <= cur + 6'h01;
            end else if (step_hit && !step_up && !at_bot) begin
                wiper_position_register_ff[p] <= cur - 6'h01;
            end
        end

        // Stored settings; reset stands in for the cell's power-up contents
        always_ff @(posedge clk_sys_in) begin
            if (!reset_n_in) begin
                for (int s = 0; s < `DWP_NUM_SETTINGS; s++) begin
                    setting_ff[p][s] <= `DWP_POS_RESET;
                end
            end else if (set_we) begin
                setting_ff[p][nv_sel_ff] <= set_val;
            end
        end

        // One-hot tap switch; registering adds the short wiper delay
        always_ff @(posedge clk_sys_in) begin
            if (!reset_n_in) begin
                tap_ff[p] <= `DWP_TAPS'(1);
            end else begin
                tap_ff[p] <= `DWP_TAPS'(1) << cur;
            end
        end
    end

    // Outputs; data pin only ever pulls low
    assign sda_out = `DWP_SDA_DRIVE_LVL;
    assign sda_oe_out = sda_oe_ff;
    assign wiper0_pos_out = wiper_position_register_ff[0];
    assign wiper1_pos_out = wiper_position_register_ff[1];
    assign tap0_sel_out = tap_ff[0];
    assign tap1_sel_out = tap_ff[1];
    assign nv_busy_out = nv_busy_ff;
endmodule : dwp_wiper_slave
`default_nettype wire
